// >>> rtl/timer8_dual_compare_pwm.sv
// Purpose: 8-bit timer/counter, two compares, normal/match-clear/fast PWM.
// Assumes: One clock, synchronous reset, classic Wishbone register slave.
// Notes:   Phase-correct modes count like normal mode with buffered
//          compares; their waveform detail is not built.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module timer8_dual_compare_pwm (
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire timer8_pkg::wb_req_t wbReq,
    output timer8_pkg::wb_rsp_t      wbRsp,
    input  wire logic               extClk,
    input  wire logic [2:0]         irqAck,
    output logic [2:0]              irq,
    output logic                    pinA,
    output logic                    pinEnA,
    output logic                    pinB,
    output logic                    pinEnB
);
    import timer8_pkg::*;

    timer_state_t s;
    timer_state_t next_s;

    function automatic logic matchAction(
        input logic       cur,
        input logic [1:0] com
    );
        unique case (com)
            COM_TOGGLE: matchAction = ~cur;
            COM_CLEAR:  matchAction = 1'b0;
            COM_SET:    matchAction = 1'b1;
            default:    matchAction = cur;
        endcase
    endfunction : matchAction

    logic       tick;
    logic       isPwm;
    logic       isFast;
    logic       clearAtTop;
    logic [7:0] topVal;
    logic       atTop;
    logic       matchA;
    logic       matchB;
    logic       extRise;
    logic       extFall;
    logic       access;
    logic       wrDo;
    logic [7:0] wrData;
    logic [2:0] setFlags;
    logic [2:0] clrFlags;
    logic [7:0] rdByte;

    always_comb begin
        next_s = s;
        setFlags = 3'h0;
        clrFlags = 3'h0;
        rdByte = 8'h00;

        // Prescaler runs freely; taps give the divided tick rates
        next_s.presc = s.presc + 10'h001;

        // Only the agreed second/third stages feed the edge decision
        next_s.extSync = {s.extSync[1:0], extClk};
        extRise = ~s.extLvl & s.extSync[1] & s.extSync[2];
        extFall = s.extLvl & ~s.extSync[1] & ~s.extSync[2];
        if (s.extSync[1] == s.extSync[2]) begin
            next_s.extLvl = s.extSync[2];
        end

        unique case (s.clkSel)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (s.presc & MASK_DIV8) == MASK_DIV8;
            CS_DIV64:    tick = (s.presc & MASK_DIV64) == MASK_DIV64;
            CS_DIV256:   tick = (s.presc & MASK_DIV256) == MASK_DIV256;
            CS_DIV1024:  tick = (s.presc & MASK_DIV1024) == MASK_DIV1024;
            CS_EXT_FALL: tick = extFall;
            CS_EXT_RISE: tick = extRise;
        endcase

        // Odd mode codes are the PWM family
        isPwm = s.wgm[0];
        isFast = (s.wgm == WGM_FAST_FF) || (s.wgm == WGM_FAST_CMPA);
        clearAtTop = isFast || (s.wgm == WGM_MATCH_CLR);
        if ((s.wgm == WGM_MATCH_CLR) || (s.wgm == WGM_FAST_CMPA)) begin
            topVal = s.cmpActA;
        end else begin
            topVal = COUNT_MAX;
        end
        atTop = (s.count == topVal);

        matchA = (s.count == s.cmpActA);
        matchB = (s.count == s.cmpActB);

        if (tick) begin
            if (clearAtTop && atTop) begin
                next_s.count = COUNT_BOTTOM;
            end else begin
                next_s.count = s.count + 8'h01;
            end

            if (isFast) begin
                setFlags[FLAG_OVF] = atTop;
            end else begin
                setFlags[FLAG_OVF] = (s.count == COUNT_MAX);
            end

            // Match held through the cycle before the tick counts
            if (!s.blockNext) begin
                setFlags[FLAG_A] = matchA;
                setFlags[FLAG_B] = matchB;
                if (!isPwm) begin
                    if (matchA) begin
                        next_s.waveA = matchAction(s.waveA, s.comA);
                    end
                    if (matchB) begin
                        next_s.waveB = matchAction(s.waveB, s.comB);
                    end
                end else if (isFast) begin
                    // Toggle is not a PWM output mode here
                    if (matchA && s.comA[1]) begin
                        next_s.waveA = s.comA[0];
                    end
                    if (matchB && s.comB[1]) begin
                        next_s.waveB = s.comB[0];
                    end
                end
            end

            // Bottom wins over a match coinciding with top
            if (isFast && atTop) begin
                if (s.comA[1]) begin
                    next_s.waveA = ~s.comA[0];
                end
                if (s.comB[1]) begin
                    next_s.waveB = ~s.comB[0];
                end
            end

            if (isPwm && atTop) begin
                next_s.cmpActA = s.cmpBufA;
                next_s.cmpActB = s.cmpBufB;
            end
            next_s.blockNext = 1'b0;
        end

        // Wishbone: ack one cycle after the request, dropped after one
        access = wbReq.cyc && wbReq.stb && !s.rsp.ack;
        next_s.rsp.ack = access;
        wrDo = s.rsp.ack && wbReq.cyc && wbReq.stb && wbReq.we &&
               wbReq.sel[0];
        wrData = wbReq.dat[7:0];

        unique case (wbReq.adr)
            ADDR_CTRL_A:
                rdByte = {s.comA, s.comB, 2'h0, s.wgm[1:0]};
            ADDR_CTRL_B:
                rdByte = {4'h0, s.wgm[2], s.clkSel};
            ADDR_COUNT:
                rdByte = s.count;
            ADDR_CMP_A:
                rdByte = isPwm ? s.cmpBufA : s.cmpActA;
            ADDR_CMP_B:
                rdByte = isPwm ? s.cmpBufB : s.cmpActB;
            ADDR_IRQ_EN:
                rdByte = {5'h00, s.irqEn};
            ADDR_FLAGS:
                rdByte = {5'h00, s.flags};
            ADDR_PIN_DIR:
                rdByte = {6'h00, s.pinDir};
            default:
                rdByte = 8'h00;
        endcase
        if (access) begin
            next_s.rsp.dat = {24'h000000, rdByte};
        end else if (s.rsp.ack) begin
            next_s.rsp.dat = 32'h00000000;
        end

        if (wrDo) begin
            unique case (wbReq.adr)
                ADDR_CTRL_A: begin
                    // Mode change leaves the output levels alone
                    next_s.comA = wrData[COM_A_POS +: 2];
                    next_s.comB = wrData[COM_B_POS +: 2];
                    next_s.wgm[1:0] = wrData[WGM_LO_POS +: 2];
                end
                ADDR_CTRL_B: begin
                    next_s.wgm[2] = wrData[WGM_HI_POS];
                    next_s.clkSel = wrData[CS_POS +: 3];
                    if (!isPwm && wrData[FORCE_A_POS]) begin
                        next_s.waveA = matchAction(s.waveA, s.comA);
                    end
                    if (!isPwm && wrData[FORCE_B_POS]) begin
                        next_s.waveB = matchAction(s.waveB, s.comB);
                    end
                end
                ADDR_COUNT: begin
                    next_s.count = wrData;
                    next_s.blockNext = 1'b1;
                end
                ADDR_CMP_A: begin
                    next_s.cmpBufA = wrData;
                    if (!isPwm) begin
                        next_s.cmpActA = wrData;
                    end
                end
                ADDR_CMP_B: begin
                    next_s.cmpBufB = wrData;
                    if (!isPwm) begin
                        next_s.cmpActB = wrData;
                    end
                end
                ADDR_IRQ_EN: begin
                    next_s.irqEn = wrData[2:0];
                end
                ADDR_FLAGS: begin
                    clrFlags = wrData[2:0];
                end
                ADDR_PIN_DIR: begin
                    next_s.pinDir = wrData[1:0];
                end
                default: begin
                    next_s.irqEn = s.irqEn;
                end
            endcase
        end

        // A new event wins over a clear in the same cycle
        clrFlags = clrFlags | irqAck;
        next_s.flags = (s.flags & ~clrFlags) | setFlags;

        next_s.irq = next_s.flags & next_s.irqEn;

        next_s.pinEnA = next_s.pinDir[DIR_A];
        next_s.pinEnB = next_s.pinDir[DIR_B];
        next_s.pinA = next_s.waveA & next_s.pinDir[DIR_A];
        next_s.pinB = next_s.waveB & next_s.pinDir[DIR_B];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wbRsp = s.rsp;
    assign irq = s.irq;
    assign pinA = s.pinA;
    assign pinEnA = s.pinEnA;
    assign pinB = s.pinB;
    assign pinEnB = s.pinEnB;

endmodule : timer8_dual_compare_pwm

// >>> rtl/timer8_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer with compare.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes:   Data sits in the low byte; upper bits read as zero.
package timer8_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_COUNT   = 8'h08;
    localparam logic [7:0] ADDR_CMP_A   = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
    localparam logic [7:0] ADDR_FLAGS   = 8'h18;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h1c;

    // timer_control_a fields
    localparam int COM_A_POS = 6;
    localparam int COM_B_POS = 4;
    localparam int WGM_LO_POS = 0;
    // timer_control_b fields
    localparam int FORCE_A_POS = 7;
    localparam int FORCE_B_POS = 6;
    localparam int WGM_HI_POS = 3;
    localparam int CS_POS = 0;
    // Flag, enable and pin direction bit positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_A = 1;
    localparam int FLAG_B = 2;
    localparam int DIR_A = 0;
    localparam int DIR_B = 1;

    // Compare output mode encodings
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // Waveform mode encodings
    localparam logic [2:0] WGM_MATCH_CLR = 3'h2;
    localparam logic [2:0] WGM_FAST_FF = 3'h3;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

    // Clock source encodings and prescale tick masks
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03f;
    localparam logic [9:0] MASK_DIV256 = 10'h0ff;
    localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmpActA;
        logic [7:0] cmpActB;
        logic [7:0] cmpBufA;
        logic [7:0] cmpBufB;
        logic [1:0] comA;
        logic [1:0] comB;
        logic [2:0] wgm;
        logic [2:0] clkSel;
        logic [2:0] irqEn;
        logic [2:0] flags;
        logic [1:0] pinDir;
        logic       waveA;
        logic       waveB;
        logic       pinA;
        logic       pinB;
        logic       pinEnA;
        logic       pinEnB;
        logic [2:0] irq;
        logic       blockNext;
        logic [9:0] presc;
        logic [2:0] extSync;
        logic       extLvl;
        wb_rsp_t    rsp;
    } timer_state_t;

endpackage : timer8_pkg

// >>> testbench/timer8_assertions.sv
// Purpose: Port checks for the 8-bit timer block.
// Assumes: Ack follows an accepted request by exactly one cycle.
// Notes:   Flags stay internal, so bus and pin relations are checked.
`timescale 1ns/1ps
module timer8_checker (
    input wire logic                core_clk,
    input wire logic                srst,
    input wire timer8_pkg::wb_req_t wbReq,
    input wire timer8_pkg::wb_rsp_t wbRsp,
    input wire logic [2:0]          irq,
    input wire logic                pinA,
    input wire logic                pinEnA,
    input wire logic                pinB,
    input wire logic                pinEnB
);
    import timer8_pkg::*;
    logic dirWr;
    assign dirWr = wbRsp.ack && wbReq.we && wbReq.sel[0]
                   && wbReq.adr == ADDR_PIN_DIR;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence busAsk;
        wbReq.cyc && wbReq.stb && !wbRsp.ack;
    endsequence
    sequence ackPulse;
        wbRsp.ack ##1 !wbRsp.ack;
    endsequence
    ack_follows_a: assert property (busAsk |=> ackPulse)
        else $error("ack did not pulse once after a request");
    ack_unasked_a: assert property (!wbReq.stb |=> !wbRsp.ack)
        else $error("ack without a request");
    dat_idle_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    dat_upper_a: assert property (
        wbRsp.ack |-> wbRsp.dat[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    pin_a_gate_a: assert property (!pinEnA |-> !pinA)
        else $error("pin a driven while not output");
    pin_b_gate_a: assert property (!pinEnB |-> !pinB)
        else $error("pin b driven while not output");
    reset_clear_a: assert property ($fell(srst) |-> irq == 3'h0
        && !pinA && !pinB && !pinEnA && !pinEnB)
        else $error("outputs not cleared by reset");
    dir_a_cause_a: assert property ($changed(pinEnA) |->
        $past(dirWr) || $past(dirWr, 2))
        else $error("pin a enable moved without a direction write");
    dir_b_cause_a: assert property ($changed(pinEnB) |->
        $past(dirWr) || $past(dirWr, 2))
        else $error("pin b enable moved without a direction write");
endmodule : timer8_checker

bind timer8_dual_compare_pwm timer8_checker chk (
    .core_clk(core_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
    .irq(irq), .pinA(pinA), .pinEnA(pinEnA), .pinB(pinB), .pinEnB(pinEnB));

// >>> testbench/wave_sink.sv
// Purpose: Load on one waveform pin; measures high and low widths.
// Assumes: The pin level only counts while its driver is enabled.
// Notes:   Widths in core clock cycles; the first width is partial.
`timescale 1ns/1ps
module wave_sink (
    input  wire logic core_clk,
    input  wire logic pin,
    input  wire logic pinEn,
    output int        highLen,
    output int        lowLen,
    output int        edges
);
    int   run = 0;
    logic last = 1'b0;
    // Two-state outputs start at zero, so one process drives each
    always @(posedge core_clk) begin
        if (pinEn === 1'b1 && pin !== last) begin
            if (last) begin
                highLen <= run;
            end else begin
                lowLen <= run;
            end
            edges <= edges + 1;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        last <= pin;
    end
endmodule : wave_sink

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the 8-bit timer block.
// Assumes: Ack one cycle after accept; /1 ticks every cycle.
// Notes:   Widths come from the pin sinks, never from the design.
`timescale 1ns/1ps
module tb;
    import timer8_pkg::*;
    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    wb_req_t    wbReq = '0;
    wb_rsp_t    wbRsp;
    logic [2:0] irqAck = 3'h0;
    logic [2:0] irq;
    logic [3:0] extCnt = 4'h0;
    logic       pinA, pinEnA, pinB, pinEnB;
    logic [31:0] rd;
    int         highA, lowA, edgesA, highB, lowB, edgesB;
    int         badCount = 0;
    int         checkCount = 0;
    int         half [8] = '{0, 2, 16, 128, 512, 2048, 32, 32};

    always #2.5 core_clk = ~core_clk;
    // External source: one falling edge every 16 core cycles
    always @(posedge core_clk) extCnt <= extCnt + 4'h1;

    timer8_dual_compare_pwm dut (
        .core_clk(core_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
        .extClk(extCnt[3]), .irqAck(irqAck), .irq(irq), .pinA(pinA),
        .pinEnA(pinEnA), .pinB(pinB), .pinEnB(pinEnB));
    wave_sink sinkA (.core_clk(core_clk), .pin(pinA), .pinEn(pinEnA),
        .highLen(highA), .lowLen(lowA), .edges(edgesA));
    wave_sink sinkB (.core_clk(core_clk), .pin(pinB), .pinEn(pinEnB),
        .highLen(highB), .lowLen(lowB), .edges(edgesB));

    task automatic giveVerdict;
        if (badCount == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : giveVerdict

    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s: expected %0h, seen %0h",
                     what, exp, got);
        end
    endtask : compare

    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, {24'h0, wd}};
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 20);
        rd = wbRsp.dat;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
        if (wbRsp.ack !== 1'b1) begin
            compare("bus ack", 32'h1, {31'h0, wbRsp.ack});
            giveVerdict();
        end
    endtask : access

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        access(1'b1, adr, wd);
    endtask : wr

    task automatic readCheck(input string what, input logic [7:0] adr,
                             input logic [7:0] exp);
        access(1'b0, adr, 8'h00);
        compare(what, {24'h0, exp}, rd);
    endtask : readCheck

    task automatic waitIrq(input int b, input logic want);
        int n;
        for (n = 0; n < 40 && irq[b] !== 1'b1; n++) begin
            @(posedge core_clk);
        end
        compare("irq", {31'h0, want}, {31'h0, irq[b]});
        if (want && irq[b] !== 1'b1) giveVerdict();
    endtask : waitIrq

    // Three edges: the first width after a change may be partial
    task automatic waitEdges(input logic useB);
        int n, e0;
        e0 = useB ? edgesB : edgesA;
        for (n = 0; n < 8000 && (useB ? edgesB : edgesA) < e0 + 3; n++) begin
            @(posedge core_clk);
        end
        if (n >= 8000) begin
            compare("pin edges", e0 + 3, useB ? edgesB : edgesA);
            giveVerdict();
        end
    endtask : waitEdges

    initial begin
        logic [2:0] wgm;
        int         i, top;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        for (i = 0; i <= 32; i += 4) begin
            readCheck("reset value", i[7:0], 8'h00);
        end
        wr(ADDR_COUNT, 8'h5a);
        readCheck("count", ADDR_COUNT, 8'h5a);
        readCheck("count held", ADDR_COUNT, 8'h5a);
        wr(ADDR_CMP_A, 8'h05);
        readCheck("compare a", ADDR_CMP_A, 8'h05);
        wr(ADDR_COUNT, 8'h05);
        wr(ADDR_IRQ_EN, 8'h02);
        wr(ADDR_CTRL_B, {5'h0, CS_DIV1});
        waitIrq(1, 1'b0);
        wr(ADDR_CTRL_B, 8'h00);
        readCheck("flags", ADDR_FLAGS, 8'h00);
        wr(ADDR_COUNT, 8'h03);
        wr(ADDR_CTRL_B, {5'h0, CS_DIV1});
        waitIrq(1, 1'b1);
        wr(ADDR_CTRL_B, 8'h00);
        readCheck("flags", ADDR_FLAGS, 8'h02);
        wr(ADDR_IRQ_EN, 8'h00);
        @(posedge core_clk);
        compare("irq masked", 32'h0, {29'h0, irq});
        irqAck <= 3'h2;
        @(posedge core_clk);
        irqAck <= 3'h0;
        readCheck("flags", ADDR_FLAGS, 8'h00);
        // Enable both pin drivers first, then force the output level
        wr(ADDR_PIN_DIR, 8'h03);
        wr(ADDR_CTRL_A, {COM_TOGGLE, 6'h00});
        wr(ADDR_CTRL_B, 8'h80);
        @(posedge core_clk);
        compare("forced pin", 32'h1, {31'h0, pinA});
        compare("pin enable", 32'h1, {31'h0, pinEnA});
        readCheck("flags", ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_A, {COM_TOGGLE, 4'h0, WGM_MATCH_CLR[1:0]});
        @(posedge core_clk);
        compare("pin kept", 32'h1, {31'h0, pinA});
        wr(ADDR_CMP_A, 8'h01);
        for (i = 1; i < 8; i++) begin
            wr(ADDR_CTRL_B, 8'h00);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL_B, {5'h0, i[2:0]});
            waitEdges(1'b0);
            compare("toggle high", half[i], highA);
            compare("toggle low", half[i], lowA);
        end
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CMP_A, 8'h09);
        wr(ADDR_CMP_B, 8'h03);
        wr(ADDR_IRQ_EN, 8'h01);
        for (i = 0; i < 4; i++) begin
            wgm = i[1] ? WGM_FAST_FF : WGM_FAST_CMPA;
            top = i[1] ? 255 : 9;
            wr(ADDR_CTRL_A,
               {2'h0, i[0] ? COM_SET : COM_CLEAR, 2'h0, wgm[1:0]});
            wr(ADDR_CTRL_B, {4'h0, wgm[2], CS_DIV1});
            waitEdges(1'b1);
            compare("pwm high", i[0] ? top - 3 : 4, highB);
            compare("pwm low", i[0] ? 4 : top - 3, lowB);
        end
        // New compare B lands in the buffer; pins follow only after top
        wr(ADDR_CMP_B, 8'h07);
        readCheck("compare b buffer", ADDR_CMP_B, 8'h07);
        waitEdges(1'b1);
        waitEdges(1'b1);
        compare("buffered high", 248, highB);
        compare("buffered low", 8, lowB);
        waitIrq(0, 1'b1);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_FLAGS, 8'h07);
        readCheck("flags", ADDR_FLAGS, 8'h00);
        giveVerdict();
    end
endmodule : tb
